// *** design/sfd_pkg.sv ***
package sfd_pkg;

  // ----------------------------------------
  // Status word bit positions, bit 0 is MSB
  // ----------------------------------------
  localparam int ST_EQ      = 2;
  localparam int ST_CARRY   = 3;
  localparam int ST_OVF     = 4;
  localparam int ST_PAR     = 5;
  localparam int ST_XOP     = 6;
  localparam int ST_CTX_LO  = 7;
  localparam int ST_CTX_HI  = 11;
  localparam int ST_MASK_LO = 12;
  localparam logic [0:15] STATUS_RESET = 16'h0000;

  // ----------------------------------------
  // First-word field positions
  // ----------------------------------------
  localparam int F_BYTE = 3;
  localparam int F_TD   = 4;
  localparam int F_DR   = 6;
  localparam int F_TS   = 10;
  localparam int F_SR   = 12;

  // ----------------------------------------
  // Register port indexes
  // ----------------------------------------
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_DECODE = 3'h1;
  localparam logic [2:0] REG_SRCADR = 3'h2;
  localparam logic [2:0] REG_DSTADR = 3'h3;

  // ----------------------------------------
  // Counts and increments
  // ----------------------------------------
  localparam logic [15:0] INC_BYTE  = 16'h0001;
  localparam logic [15:0] INC_WORD  = 16'h0002;
  localparam logic [3:0]  CRU_MAXP  = 4'h8;

  // Address type codes
  localparam logic [1:0] T_DIRECT = 2'h0;
  localparam logic [1:0] T_IND    = 2'h1;
  localparam logic [1:0] T_SYM    = 2'h2;
  localparam logic [1:0] T_AUTO   = 2'h3;

  typedef enum logic [4:0] {
    OP_NONE      = 5'b00000,
    OP_ADD       = 5'b00001,
    OP_SUB       = 5'b00010,
    OP_DEC       = 5'b00011,
    OP_INC       = 5'b00100,
    OP_SLA       = 5'b00101,
    OP_SIGNED_DIVIDE      = 5'b00110,
    OP_FP        = 5'b00111,
    OP_BMOVE     = 5'b01000,
    OP_BLOGIC    = 5'b01001,
    OP_CRU_MULTI = 5'b01010,
    OP_TB        = 5'b01011,
    OP_XOP       = 5'b01100,
    OP_LOAD_MASK_IMMEDIATE      = 5'b01101,
    OP_RESET_MASK_INSTRUCTION      = 5'b01110,
    OP_LST       = 5'b01111,
    OP_RETURN_FROM_CONTEXT      = 5'b10000,
    OP_INT       = 5'b10001,
    OP_RESET_INT = 5'b10010
  } sfd_op_e;

  typedef enum logic [2:0] {
    A_IDLE = 3'b000,
    A_OPND = 3'b001,
    A_RREG = 3'b010,
    A_WREG = 3'b011,
    A_REXT = 3'b100,
    A_WEXT = 3'b101,
    A_INCW = 3'b110,
    A_DONE = 3'b111
  } sfd_addr_e;

endpackage

// *** design/sfd_status_decode.sv ***
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module sfd_status_decode (
  input  wire logic           CLK,
  input  wire logic           RESET,
  // Register port
  input  wire logic [2:0]     REG_ADDR,
  input  wire logic [15:0]    REG_WDATA,
  input  wire logic           REG_WR,
  input  wire logic           REG_RD,
  output logic      [15:0]    REG_RDATA,
  // Execution status events
  input  wire logic           EXEC_VALID,
  input  wire sfd_pkg::sfd_op_e EXEC_OP,
  input  wire logic           EXEC_BYTE,
  input  wire logic [15:0]    SRC_VAL,
  input  wire logic [15:0]    DST_VAL,
  input  wire logic [15:0]    RES_VAL,
  input  wire logic [3:0]     SHIFT_COUNT,
  input  wire logic [3:0]     CRU_COUNT,
  input  wire logic           DIV_OVF,
  input  wire logic           FP_EXC,
  input  wire logic           CARRY_OUT,
  input  wire logic [3:0]     INT_LEVEL,
  input  wire logic           CRU_IN,
  output logic      [15:0]    STATUS,
  // Instruction decode and operand addressing
  input  wire logic           DEC_LOAD,
  input  wire logic [15:0]    INSTR_WORD,
  input  wire logic [15:0]    INSTR_PC,
  input  wire logic [15:0]    WP,
  input  wire logic           DEC_HAS_SRC,
  input  wire logic           DEC_HAS_DST,
  input  wire logic           DEC_IMMEDIATE,
  output logic                DEC_BYTE,
  output logic      [1:0]     DEC_WORDS,
  output logic      [15:0]    SRC_ADDR,
  output logic      [15:0]    DST_ADDR,
  output logic                SRC_IS_REG,
  output logic                DST_IS_REG,
  output logic      [15:0]    IMM_ADDR,
  output logic                ADDR_BUSY,
  output logic                ADDR_DONE,
  output logic                MEM_RD,
  output logic                MEM_WR,
  output logic      [15:0]    MEM_ADDR,
  output logic      [15:0]    MEM_WDATA,
  input  wire logic [15:0]    MEM_RDATA
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Overflow of arithmetic left shift; count 0 means 16
  function automatic logic sla_ovf(input logic [15:0] v,
                                   input logic [3:0] c);
    logic        r;
    logic [4:0]  n;
    r = 1'b0;
    n = (c == 4'h0) ? 5'h10 : {1'b0, c};
    for (int k = 1; k < 16; k++)
      if (5'(k) <= n && v[15-k] != v[15])
        r = 1'b1;
    return r;
  endfunction

  // Odd parity of the left byte
  function automatic logic odd_byte(input logic [15:0] v);
    return ^v[15:8];
  endfunction

  // Workspace register address
  function automatic logic [15:0] ws_addr(input logic [15:0] wp,
                                          input logic [3:0] r);
    return wp + {11'h000, r, 1'b0};
  endfunction

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  logic [0:15] status;
  logic [0:15] next_status;
  logic [0:15] wdata_asc;
  logic        cru_meta;
  logic        cru_sync;
  logic        sw_status_wr;
  logic        src_s;
  logic        dst_s;
  logic        res_s;
  logic        fp_ovf;
  logic        div_ovf;

  assign src_s        = SRC_VAL[15];
  assign dst_s        = DST_VAL[15];
  assign res_s        = RES_VAL[15];
  assign fp_ovf       = FP_EXC;
  assign div_ovf      = (SRC_VAL == 16'h0000) || DIV_OVF;
  assign sw_status_wr = REG_WR && (REG_ADDR == sfd_pkg::REG_STATUS);
  assign wdata_asc    = REG_WDATA;

  // Input bit comes from a pin: two stages before use
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cru_meta <= 1'b0;
      cru_sync <= 1'b0;
    end
    else
    begin
      cru_meta <= CRU_IN;
      cru_sync <= cru_meta;
    end
  end

  // Per-op update; untouched bits keep value
  always_comb
  begin
    next_status = status;
    if (EXEC_VALID)
    begin
      case (EXEC_OP)
        sfd_pkg::OP_ADD:
        begin
          next_status[sfd_pkg::ST_OVF] =
            (src_s == dst_s) && (res_s != dst_s);
          if (EXEC_BYTE)
            next_status[sfd_pkg::ST_PAR] = odd_byte(RES_VAL);
        end
        sfd_pkg::OP_SUB:
        begin
          next_status[sfd_pkg::ST_OVF] =
            (src_s != dst_s) && (res_s != dst_s);
          if (EXEC_BYTE)
            next_status[sfd_pkg::ST_PAR] = odd_byte(RES_VAL);
        end
        sfd_pkg::OP_DEC:
          next_status[sfd_pkg::ST_OVF] = src_s && !res_s;
        sfd_pkg::OP_INC:
          next_status[sfd_pkg::ST_OVF] = !src_s && res_s;
        sfd_pkg::OP_SLA:
          next_status[sfd_pkg::ST_OVF] =
            sla_ovf(SRC_VAL, SHIFT_COUNT);
        sfd_pkg::OP_SIGNED_DIVIDE:
        begin
          // Only carry and overflow move on overflow
          next_status[sfd_pkg::ST_OVF] = div_ovf;
          if (div_ovf)
            next_status[sfd_pkg::ST_CARRY] = CARRY_OUT;
        end
        sfd_pkg::OP_FP:
        begin
          next_status[sfd_pkg::ST_OVF] = fp_ovf;
          if (fp_ovf)
            next_status[sfd_pkg::ST_CARRY] = CARRY_OUT;
        end
        sfd_pkg::OP_BMOVE:
          next_status[sfd_pkg::ST_PAR] = odd_byte(SRC_VAL);
        sfd_pkg::OP_BLOGIC:
          next_status[sfd_pkg::ST_PAR] = odd_byte(RES_VAL);
        sfd_pkg::OP_CRU_MULTI:
          next_status[sfd_pkg::ST_PAR] =
            (CRU_COUNT != 4'h0) && (CRU_COUNT <= sfd_pkg::CRU_MAXP)
            && odd_byte(SRC_VAL);
        sfd_pkg::OP_TB:
          next_status[sfd_pkg::ST_EQ] = cru_sync;
        sfd_pkg::OP_XOP:
        begin
          next_status[sfd_pkg::ST_XOP] = 1'b1;
          next_status[sfd_pkg::ST_CTX_LO:sfd_pkg::ST_CTX_HI] =
            5'h00;
        end
        sfd_pkg::OP_LOAD_MASK_IMMEDIATE:
          next_status[sfd_pkg::ST_MASK_LO:15] = SRC_VAL[3:0];
        sfd_pkg::OP_RESET_MASK_INSTRUCTION:
          next_status[sfd_pkg::ST_MASK_LO:15] = 4'h0;
        sfd_pkg::OP_LST,
        sfd_pkg::OP_RETURN_FROM_CONTEXT:
          next_status = SRC_VAL;
        sfd_pkg::OP_INT:
        begin
          next_status[sfd_pkg::ST_CTX_LO:sfd_pkg::ST_CTX_HI] =
            5'h00;
          // Level zero is the load interrupt: mask kept
          if (INT_LEVEL != 4'h0)
            next_status[sfd_pkg::ST_MASK_LO:15] =
              INT_LEVEL - 4'h1;
        end
        sfd_pkg::OP_RESET_INT:
          next_status = sfd_pkg::STATUS_RESET;
        default:
          next_status = status;
      endcase
    end
    else if (sw_status_wr)
      next_status = wdata_asc;
  end

  // Executed events win over a software write
  always_ff @(posedge CLK)
  begin
    if (RESET)
      status <= sfd_pkg::STATUS_RESET;
    else
      status <= next_status;
  end

  assign STATUS = status;

  // ----------------------------------------
  // First-word decode
  // ----------------------------------------
  logic [0:15]     iw;
  logic [0:15]     iw_in;
  logic            has_src;
  logic            has_dst;
  logic            imm;
  logic [15:0]     ext_ptr;
  logic [15:0]     wp_q;
  logic [1:0]      t_s;
  logic [1:0]      t_d;
  logic [3:0]      r_s;
  logic [3:0]      r_d;
  logic            byte_op;
  logic            ext_s;
  logic            ext_d;

  assign iw_in   = INSTR_WORD;
  assign byte_op = iw[sfd_pkg::F_BYTE];
  assign t_d     = iw[sfd_pkg::F_TD +: 2];
  assign r_d     = iw[sfd_pkg::F_DR +: 4];
  assign t_s     = iw[sfd_pkg::F_TS +: 2];
  assign r_s     = iw[sfd_pkg::F_SR +: 4];
  assign ext_s   = has_src && (t_s == sfd_pkg::T_SYM);
  assign ext_d   = has_dst && (t_d == sfd_pkg::T_SYM);

  // Word count: at most one extra word per field
  assign DEC_WORDS = 2'h1 + {1'b0, imm} + {1'b0, ext_s}
                     + {1'b0, ext_d};
  assign DEC_BYTE  = byte_op;

  // ----------------------------------------
  // Operand address sequencer
  // ----------------------------------------
  sfd_pkg::sfd_addr_e state;
  sfd_pkg::sfd_addr_e next_state;
  logic            side;
  logic [1:0]      cur_t;
  logic [3:0]      cur_r;
  logic [15:0]     cur_ws;
  logic [15:0]     sym;
  logic [15:0]     inc;
  logic            opnd_fin;
  logic [15:0]     fin_addr;
  logic            fin_reg;
  logic            cur_has;

  // An absent field must not capture an address or eat an extension word
  assign cur_has = side ? has_dst : has_src;
  assign cur_t  = side ? t_d : t_s;
  assign cur_r  = side ? r_d : r_s;
  assign cur_ws = ws_addr(wp_q, cur_r);
  assign inc    = byte_op ? sfd_pkg::INC_BYTE
                          : sfd_pkg::INC_WORD;

  // Operand address ready this cycle
  assign opnd_fin =
    (state == sfd_pkg::A_OPND && cur_has
     && cur_t == sfd_pkg::T_DIRECT) ||
    (state == sfd_pkg::A_WREG && cur_t != sfd_pkg::T_AUTO) ||
    (state == sfd_pkg::A_WEXT && cur_r == 4'h0) ||
    (state == sfd_pkg::A_INCW);
  assign fin_reg = (state == sfd_pkg::A_OPND);
  assign fin_addr =
    (state == sfd_pkg::A_OPND) ? cur_ws :
    (state == sfd_pkg::A_WEXT) ? MEM_RDATA :
    (state == sfd_pkg::A_INCW) ? sym :
    (cur_t == sfd_pkg::T_SYM)  ? sym + MEM_RDATA
                               : MEM_RDATA;

  // Next state of the sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      sfd_pkg::A_IDLE:
        if (DEC_LOAD)
          next_state = sfd_pkg::A_OPND;
      sfd_pkg::A_OPND:
        if (!has_src && !side && has_dst)
          next_state = sfd_pkg::A_OPND;
        else if (!(side ? has_dst : has_src))
          next_state = sfd_pkg::A_DONE;
        else if (cur_t == sfd_pkg::T_SYM)
          next_state = sfd_pkg::A_REXT;
        else if (cur_t != sfd_pkg::T_DIRECT)
          next_state = sfd_pkg::A_RREG;
      sfd_pkg::A_RREG:
        next_state = sfd_pkg::A_WREG;
      sfd_pkg::A_WREG:
        if (cur_t == sfd_pkg::T_AUTO)
          next_state = sfd_pkg::A_INCW;
      sfd_pkg::A_REXT:
        next_state = sfd_pkg::A_WEXT;
      sfd_pkg::A_WEXT:
        if (cur_r != 4'h0)
          next_state = sfd_pkg::A_RREG;
      sfd_pkg::A_INCW:
        next_state = sfd_pkg::A_INCW;
      sfd_pkg::A_DONE:
        next_state = sfd_pkg::A_IDLE;
      default:
        next_state = sfd_pkg::A_IDLE;
    endcase
    // Source side first, then the destination
    if (opnd_fin)
      next_state = (!side && has_dst) ? sfd_pkg::A_OPND
                                      : sfd_pkg::A_DONE;
  end

  // Skipping a missing source field
  logic skip_src;
  assign skip_src = (state == sfd_pkg::A_OPND) && !side && !has_src;

  // Latch the decoded word and run the walk
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state <= sfd_pkg::A_IDLE;
      iw <= 16'h0000;
      has_src <= 1'b0;
      has_dst <= 1'b0;
      imm <= 1'b0;
      wp_q <= 16'h0000;
      ext_ptr <= 16'h0000;
      IMM_ADDR <= 16'h0000;
      side <= 1'b0;
      sym <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (state == sfd_pkg::A_IDLE && DEC_LOAD)
      begin
        iw <= iw_in;
        has_src <= DEC_HAS_SRC;
        has_dst <= DEC_HAS_DST;
        imm <= DEC_IMMEDIATE;
        wp_q <= WP;
        ext_ptr <= INSTR_PC + sfd_pkg::INC_WORD;
        IMM_ADDR <= INSTR_PC + sfd_pkg::INC_WORD;
        side <= 1'b0;
      end
      if (skip_src || (opnd_fin && !side))
        side <= 1'b1;
      if (state == sfd_pkg::A_OPND && cur_has
          && cur_t == sfd_pkg::T_SYM)
        ext_ptr <= ext_ptr + sfd_pkg::INC_WORD;
      if (state == sfd_pkg::A_WEXT)
        sym <= MEM_RDATA;
      if (state == sfd_pkg::A_WREG && cur_t == sfd_pkg::T_AUTO)
        sym <= MEM_RDATA;
    end
  end

  // Memory request address and write data
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 16'h0000;
    end
    else if (state == sfd_pkg::A_OPND)
      MEM_ADDR <= (cur_t == sfd_pkg::T_SYM) ? ext_ptr : cur_ws;
    else if (state == sfd_pkg::A_WEXT)
      MEM_ADDR <= cur_ws;
    else if (state == sfd_pkg::A_WREG)
    begin
      MEM_ADDR <= cur_ws;
      MEM_WDATA <= MEM_RDATA + inc;
    end
  end

  // Captured operand addresses
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      SRC_ADDR <= 16'h0000;
      DST_ADDR <= 16'h0000;
      SRC_IS_REG <= 1'b0;
      DST_IS_REG <= 1'b0;
    end
    else if (opnd_fin && !side)
    begin
      SRC_ADDR <= fin_addr;
      SRC_IS_REG <= fin_reg;
    end
    else if (opnd_fin)
    begin
      DST_ADDR <= fin_addr;
      DST_IS_REG <= fin_reg;
    end
  end

  // Memory strobes follow the state directly
  assign MEM_RD    = (state == sfd_pkg::A_RREG)
                     || (state == sfd_pkg::A_REXT);
  assign MEM_WR    = (state == sfd_pkg::A_INCW);
  assign ADDR_DONE = (state == sfd_pkg::A_DONE);
  assign ADDR_BUSY = (state != sfd_pkg::A_IDLE);

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [15:0] rd_mux;
  logic [15:0] dec_view;

  assign dec_view = {8'h00, ADDR_BUSY, DEC_WORDS, byte_op,
                     t_d, t_s};
  assign rd_mux =
    (REG_ADDR == sfd_pkg::REG_STATUS) ? status :
    (REG_ADDR == sfd_pkg::REG_DECODE) ? dec_view :
    (REG_ADDR == sfd_pkg::REG_SRCADR) ? SRC_ADDR :
    (REG_ADDR == sfd_pkg::REG_DSTADR) ? DST_ADDR : 16'h0000;

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge CLK)
  begin
    if (RESET)
      REG_RDATA <= 16'h0000;
    else
      REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_ADD_OVF: assert property (EXEC_VALID && EXEC_OP == sfd_pkg::OP_ADD
    |=> status[4] == $past((src_s == dst_s) && (res_s != dst_s)))
    else $error("add overflow wrong");
  AST_SUB_OVF: assert property (EXEC_VALID && EXEC_OP == sfd_pkg::OP_SUB
    |=> status[4] == $past((src_s != dst_s) && (res_s != dst_s)))
    else $error("sub overflow wrong");
  AST_CRU_PAR: assert property (EXEC_VALID
    && EXEC_OP == sfd_pkg::OP_CRU_MULTI && CRU_COUNT > 4'h8
    |=> !status[5])
    else $error("parity set for long count");
  AST_XOP_CTX: assert property (EXEC_VALID && EXEC_OP == sfd_pkg::OP_XOP
    |=> status[6] && status[7:11] == 5'h00)
    else $error("trap status wrong");
  AST_RESET_INT: assert property (EXEC_VALID
    && EXEC_OP == sfd_pkg::OP_RESET_INT |=> status == 16'h0000)
    else $error("reset interrupt left bits");
  AST_DIV_KEEP: assert property (EXEC_VALID
    && EXEC_OP == sfd_pkg::OP_SIGNED_DIVIDE
    |=> {status[0:2], status[5:15]} == $past({status[0:2],
        status[5:15]}))
    else $error("divide touched other bits");
  AST_INT_MASK: assert property (EXEC_VALID && EXEC_OP == sfd_pkg::OP_INT
    && INT_LEVEL != 4'h0 |=> status[12:15] == $past(INT_LEVEL)
    - 4'h1)
    else $error("interrupt mask wrong");
  AST_IDLE_KEEP: assert property (!EXEC_VALID && !sw_status_wr
    |=> $stable(status))
    else $error("status changed unprompted");
  AST_AUTO_WB: assert property (MEM_WR |-> $past(MEM_RD, 2))
    else $error("autoincrement without read");
  AST_WALK_LEN: assert property ($rose(ADDR_BUSY)
    |-> ##[1:14] ADDR_DONE)
    else $error("address walk too long");
  AST_RD_DATA: assert property (!$past(REG_RD)
    |-> REG_RDATA == 16'h0000)
    else $error("read data outside slot");

  COV_AUTO: cover property (MEM_WR);
  COV_TWO_EXT: cover property (ADDR_DONE && DEC_WORDS == 2'h3);
  COV_INT: cover property (EXEC_VALID && EXEC_OP == sfd_pkg::OP_INT);
  COV_SLA: cover property (EXEC_VALID && EXEC_OP == sfd_pkg::OP_SLA
    && sla_ovf(SRC_VAL, SHIFT_COUNT));

endmodule

// *** dv/sfd_mem_model.sv ***
`timescale 1ns/1ps
module sfd_mem_model (
  input  wire logic        CLK,
  input  wire logic        MEM_RD,
  input  wire logic        MEM_WR,
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [15:0] MEM_WDATA,
  output logic      [15:0] MEM_RDATA
);
  // -------------------------------------------------
  // Program and workspace memory, 1K words
  // -------------------------------------------------
  logic [15:0] mem [0:1023];

  initial MEM_RDATA = 16'h0000;

  // Read data stand only in the cycle after the read strobe; at any
  // other time the bus toggles so that stale data never looks valid
  always @(posedge CLK)
  begin
    if (MEM_WR)
      mem[MEM_ADDR[10:1]] <= MEM_WDATA;
    if (MEM_RD)
      MEM_RDATA <= mem[MEM_ADDR[10:1]];
    else
      MEM_RDATA <= ~MEM_RDATA;
  end
endmodule

// *** dv/sfd_status_decode_tb.sv ***
`timescale 1ns/1ps
module sfd_status_decode_tb;
  logic        CLK = 1'h0, RESET = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0;
  logic        EXEC_VALID = 1'h0, EXEC_BYTE = 1'h0, DIV_OVF = 1'h0;
  logic        FP_EXC = 1'h0, CARRY_OUT = 1'h0, CRU_IN = 1'h0;
  logic        DEC_LOAD = 1'h0, DEC_HAS_SRC = 1'h0, DEC_HAS_DST = 1'h0;
  logic        DEC_IMMEDIATE = 1'h0, DEC_BYTE, SRC_IS_REG, DST_IS_REG;
  logic        ADDR_BUSY, ADDR_DONE, MEM_RD, MEM_WR;
  logic [1:0]  DEC_WORDS;
  logic [2:0]  REG_ADDR = 3'h0;
  logic [3:0]  SHIFT_COUNT = 4'h1, CRU_COUNT = 4'h1, INT_LEVEL = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000, SRC_VAL = 16'h0000;
  logic [15:0] DST_VAL = 16'h0000, RES_VAL = 16'h0000;
  logic [15:0] INSTR_WORD = 16'h0000, INSTR_PC = 16'h0080, WP = 16'h0100;
  logic [15:0] REG_RDATA, STATUS, SRC_ADDR, DST_ADDR, IMM_ADDR;
  logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, rd_val;
  sfd_pkg::sfd_op_e EXEC_OP = sfd_pkg::OP_NONE;
  int          num_errors = 0, cmp_count = 0;

  sfd_status_decode dut (.*);
  sfd_mem_model mem_i (.CLK, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA,
                       .MEM_RDATA);

  // Free-running 100 MHz clock
  always #5 CLK = ~CLK;

  // -------------------------------------------------
  // Access tasks and comparisons
  // -------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_WR <= 1'h1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'h0;
    #1;
  endtask

  // Read data are valid only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge CLK);
    REG_RD <= 1'h1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'h0;
    #1;
    rd_val = REG_RDATA;
  endtask

  task automatic ex(input sfd_pkg::sfd_op_e op, input logic [15:0] s,
                    input logic [15:0] d = 16'h0000, r = 16'h0000,
                    input logic [3:0] c = 4'h1, input logic [2:0] f = 3'h0,
                    input logic b = 1'h0);
    @(posedge CLK);
    EXEC_VALID <= 1'h1;
    EXEC_OP <= op;
    EXEC_BYTE <= b;
    SRC_VAL <= s;
    DST_VAL <= d;
    RES_VAL <= r;
    SHIFT_COUNT <= c;
    CRU_COUNT <= c;
    INT_LEVEL <= c;
    {CARRY_OUT, DIV_OVF, FP_EXC} <= f;
    @(posedge CLK);
    EXEC_VALID <= 1'h0;
    #1;
  endtask

  // Overflow case; flag preset to one, XOP, context and mask bits must hold
  task automatic ovc(input sfd_pkg::sfd_op_e op, input logic [15:0] s, d, r,
                     input logic v, input logic [3:0] c = 4'h1,
                     input logic [2:0] f = 3'h0);
    wr(3'h0, 16'h0da5);
    ex(op, s, d, r, c, f);
    chk(STATUS & 16'h0bff, {4'h0, v, 11'h1a5});
  endtask

  // Byte parity case, flag preset to the opposite value
  task automatic par(input sfd_pkg::sfd_op_e op, input logic [15:0] s, r,
                     input logic [3:0] c, input logic p);
    wr(3'h0, {5'h00, ~p, 10'h000});
    ex(op, s, 16'h0000, r, c, 3'h0, 1'h1);
    chk(STATUS & 16'h0400, {5'h00, p, 10'h000});
  endtask

  // Address walk; a hung sequencer ends the run
  task automatic dc(input logic [15:0] w, input logic [2:0] h,
                    input logic [15:0] es, ed, input logic [4:0] ef);
    int n;
    @(posedge CLK);
    DEC_LOAD <= 1'h1;
    INSTR_WORD <= w;
    {DEC_HAS_SRC, DEC_HAS_DST, DEC_IMMEDIATE} <= h;
    @(posedge CLK);
    DEC_LOAD <= 1'h0;
    n = 0;
    #1;
    while (ADDR_DONE !== 1'h1)
    begin
      @(posedge CLK);
      #1;
      n++;
      if (n > 40)
      begin
        num_errors++;
        $display("mismatch at %0t: address walk never ended", $time);
        end_of_test();
      end
    end
    @(posedge CLK);
    #1;
    chk({14'h0000, DEC_WORDS}, {14'h0000, ef[1:0]});
    chk(IMM_ADDR, 16'h0082);
    if (!h[0])
    begin
      chk(SRC_ADDR, es);
      chk(DST_ADDR, ed);
      chk({11'h000, SRC_IS_REG, DST_IS_REG, DEC_BYTE, DEC_WORDS},
          {11'h000, ef});
    end
  endtask

  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial
  begin
    logic [3:0] lvs [3] = '{4'h5, 4'h1, 4'hf};
    mem_i.mem[10'h080] = 16'h0500;
    mem_i.mem[10'h082] = 16'h0300;
    mem_i.mem[10'h083] = 16'h0400;
    mem_i.mem[10'h087] = 16'h0004;
    mem_i.mem[10'h041] = 16'h0200;
    mem_i.mem[10'h042] = 16'h0202;
    repeat (5) @(posedge CLK);
    RESET <= 1'h0;
    #1;
    chk(STATUS, 16'h0000);
    wr(3'h0, 16'hc3a5);
    rd(3'h0);
    chk(rd_val, 16'hc3a5);
    rd(3'h5);
    chk(rd_val, 16'h0000);
    ovc(sfd_pkg::OP_ADD, 16'h7fff, 16'h0001, 16'h8000, 1'h1);
    ovc(sfd_pkg::OP_ADD, 16'h8000, 16'h7fff, 16'hffff, 1'h0);
    ovc(sfd_pkg::OP_SUB, 16'h0001, 16'h8000, 16'h7fff, 1'h1);
    ovc(sfd_pkg::OP_SUB, 16'h0001, 16'h0003, 16'h0002, 1'h0);
    ovc(sfd_pkg::OP_DEC, 16'h8000, 16'h0000, 16'h7fff, 1'h1);
    ovc(sfd_pkg::OP_INC, 16'h7fff, 16'h0000, 16'h8000, 1'h1);
    ovc(sfd_pkg::OP_INC, 16'hffff, 16'h0000, 16'h0000, 1'h0);
    ovc(sfd_pkg::OP_SLA, 16'h4000, 16'h0000, 16'h0000, 1'h1,
        4'h2);
    ovc(sfd_pkg::OP_SLA, 16'h2000, 16'h0000, 16'h4000, 1'h0);
    ovc(sfd_pkg::OP_SIGNED_DIVIDE, 16'h0000, 16'h0005, 16'h0000, 1'h1);
    ovc(sfd_pkg::OP_FP, 16'h0003, 16'h0000, 16'h0000, 1'h1,
        4'h1, 3'h1);
    ovc(sfd_pkg::OP_FP, 16'h0003, 16'h0000, 16'h0000, 1'h0);
    wr(3'h0, 16'hf7ff);
    ex(sfd_pkg::OP_SIGNED_DIVIDE, 16'h0003, 16'h0000, 16'h0000, 4'h1, 3'h2);
    chk(STATUS, 16'hefff);
    wr(3'h0, 16'h0000);
    ex(sfd_pkg::OP_FP, 16'h0003, 16'h0000, 16'h0000, 4'h1, 3'h5);
    chk(STATUS, 16'h1800);
    par(sfd_pkg::OP_BMOVE, 16'h0700, 16'h0000, 4'h1, 1'h1);
    par(sfd_pkg::OP_BMOVE, 16'h0300, 16'h0100, 4'h1, 1'h0);
    par(sfd_pkg::OP_BLOGIC, 16'h0300, 16'h0100, 4'h1, 1'h1);
    par(sfd_pkg::OP_ADD, 16'h0100, 16'h0300, 4'h1, 1'h0);
    par(sfd_pkg::OP_CRU_MULTI, 16'h0701, 16'h0000, 4'h8, 1'h1);
    par(sfd_pkg::OP_CRU_MULTI, 16'h0701, 16'h0000, 4'h9, 1'h0);
    par(sfd_pkg::OP_CRU_MULTI, 16'h0701, 16'h0000, 4'h0, 1'h0);
    wr(3'h0, 16'h01f7);
    ex(sfd_pkg::OP_XOP, 16'h0000);
    chk(STATUS & 16'h03ff, 16'h0207);
    // Each level leaves the mask one step more urgent
    foreach (lvs[i])
    begin
      wr(3'h0, 16'h01f7);
      ex(sfd_pkg::OP_INT, 16'h0000, 16'h0000, 16'h0000, lvs[i]);
      chk(STATUS & 16'h01ff, {12'h000, lvs[i] - 4'h1});
    end
    wr(3'h0, 16'h0007);
    ex(sfd_pkg::OP_INT, 16'h0000, 16'h0000, 16'h0000, 4'h0);
    chk(STATUS & 16'h000f, 16'h0007);
    wr(3'h0, 16'h5a53);
    ex(sfd_pkg::OP_LOAD_MASK_IMMEDIATE, 16'h000a);
    chk(STATUS, 16'h5a5a);
    ex(sfd_pkg::OP_RESET_MASK_INSTRUCTION, 16'h000f);
    chk(STATUS, 16'h5a50);
    ex(sfd_pkg::OP_NONE, 16'hffff);
    chk(STATUS, 16'h5a50);
    ex(sfd_pkg::OP_LST, 16'h1234);
    chk(STATUS, 16'h1234);
    ex(sfd_pkg::OP_RETURN_FROM_CONTEXT, 16'habcd);
    chk(STATUS, 16'habcd);
    ex(sfd_pkg::OP_RESET_INT, 16'h0000);
    chk(STATUS, 16'h0000);
    // The input bit passes a two-flop synchroniser first
    for (int i = 1; i >= 0; i--)
    begin
      CRU_IN <= 1'(i);
      repeat (3) @(posedge CLK);
      ex(sfd_pkg::OP_TB, 16'h0000);
      chk(STATUS & 16'h2000, {2'h0, 1'(i), 13'h0000});
    end
    dc(16'ha001, 3'h6, 16'h0102, 16'h0100, 5'h19);
    dc(16'h74d2, 3'h6, 16'h0300, 16'h0400, 5'h05);
    dc(16'hac01, 3'h6, 16'h0102, 16'h0500, 5'h11);
    chk(mem_i.mem[10'h080], 16'h0502);
    dc(16'hbc01, 3'h6, 16'h0102, 16'h0502, 5'h15);
    chk(mem_i.mem[10'h080], 16'h0503);
    dc(16'hc820, 3'h6, 16'h0200, 16'h0202, 5'h03);
    dc(16'ha1a7, 3'h6, 16'h0204, 16'h010c, 5'h0a);
    rd(3'h1);
    chk(rd_val, 16'h0042);
    rd(3'h2);
    chk(rd_val, 16'h0204);
    dc(16'h0300, 3'h1, 16'h0000, 16'h0000, 5'h02);
    chk(SRC_ADDR, 16'h0204);
    end_of_test();
  end
endmodule
